// ### core/dsd_pkg.sv
package dsd_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] REGFILE_LO = 16'h0000;
  localparam logic [15:0] REGFILE_HI = 16'h001F;
  localparam logic [15:0] STDIO_LO = 16'h0020;
  localparam logic [15:0] STDIO_HI = 16'h005F;
  localparam logic [15:0] EXTIO_LO = 16'h0060;
  localparam logic [15:0] EXTIO_HI = 16'h00FF;
  localparam logic [15:0] SRAM_LO = 16'h0100;
  localparam logic [15:0] SRAM_HI = 16'h08FF;
  localparam int SRAM_BYTES = 2048;
  localparam int EE_BYTES = 1024;
  localparam logic [15:0] IO_TO_DATA = 16'h0020;
  localparam logic [5:0] IO_BIT_MAX = 6'h1F;
  localparam logic [5:0] IO_SCRATCH0 = 6'h1E;
  localparam logic [5:0] IO_EE_CTRL = 6'h1F;
  localparam logic [5:0] IO_EE_DATA = 6'h20;
  localparam logic [5:0] IO_EE_ADDR_LO = 6'h21;
  localparam logic [5:0] IO_EE_ADDR_HI = 6'h22;
  localparam logic [5:0] IO_SCRATCH1 = 6'h2A;
  localparam logic [5:0] IO_SCRATCH2 = 6'h2B;
  localparam logic [5:0] IO_FLAGS = 6'h1D;
  localparam logic [7:0] EE_ADDR_HI_MASK = 8'h03;
  localparam int CTL_READ_BIT = 0;
  localparam int CTL_WRITE_BIT = 1;
  localparam int CTL_MASTER_BIT = 2;
  localparam logic [7:0] CTL_RW_MASK = 8'h07;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int MASTER_WINDOW_CYC = 4;
  localparam int READ_STALL_CYC = 4;
  localparam int WRITE_STALL_CYC = 2;
  localparam int SRAM_ACCESS_CYC = 2;
  localparam int DISP_MAX = 63;
  localparam int EE_WRITE_CYC_DEF = 34000;
  typedef enum logic [2:0] {REG_NONE, REG_FILE, REG_IO, REG_EXTIO, REG_SRAM} region_t;
  typedef enum logic [1:0] {MODE_PLAIN, MODE_DISP, MODE_PREDEC, MODE_POSTINC} addr_mode_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic io_short;
    logic bit_set;
    logic bit_clr;
    logic [2:0] bit_idx;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cpu_req_t;
endpackage : dsd_pkg

// ### core/dsd_stall_counter.sv
`timescale 1ns/1ps
`default_nettype none
module dsd_stall_counter
  import dsd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [2:0] i_cycles,
  output logic o_busy
);
  logic [2:0] count;
  logic [2:0] next_count;
  always_comb
  begin
    next_count = count;
    if (i_start)
      next_count = i_cycles;
    else if (count != 3'h0)
      next_count = count - 3'h1;
  end
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      count <= 3'h0;
    else
      count <= next_count;
  end
  assign o_busy = (count != 3'h0);
endmodule : dsd_stall_counter
`default_nettype wire

// ### core/dsd_pointer_unit.sv
`timescale 1ns/1ps
`default_nettype none
module dsd_pointer_unit
  import dsd_pkg::*;
(
  input wire logic [15:0] i_pointer,
  input wire addr_mode_t i_mode,
  input wire logic [5:0] i_disp,
  output logic [15:0] o_addr,
  output logic [15:0] o_pointer_new,
  output logic o_writeback
);
  always_comb
  begin
    o_addr = i_pointer;
    o_pointer_new = i_pointer;
    o_writeback = 1'b0;
    unique case (i_mode)
      MODE_PLAIN: o_addr = i_pointer;
      MODE_DISP: o_addr = i_pointer + {10'h000, i_disp};
      MODE_PREDEC:
      begin
        o_addr = i_pointer - 16'h0001;
        o_pointer_new = i_pointer - 16'h0001;
        o_writeback = 1'b1;
      end
      MODE_POSTINC:
      begin
        o_addr = i_pointer;
        o_pointer_new = i_pointer + 16'h0001;
        o_writeback = 1'b1;
      end
    endcase
  end
endmodule : dsd_pointer_unit
`default_nettype wire

// ### core/data_space_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - 0x00-0x1F selects working registers
// - 0x20-0x5F selects standard I/O
// - extended I/O only by data loads/stores
// - SRAM from 0x0100 up to 0x08FF
// - SRAM access takes two cycles
// - displacement adds unsigned up to 63
// - pointer pre-decrement, post-increment, written back
// - port I/O 0x00-0x3F, data plus 0x20
// - low I/O supports bit set/clear/test
// - bit ops touch only addressed bit
// - some flags clear by writing one
// - EEPROM read stalls CPU four cycles
// - EEPROM write stalls CPU two cycles
// - EEPROM separate byte space, 1K bytes
// - self-timed write with pollable busy
// - write in progress survives reset
// - address regs at I/O 0x22, 0x21
// - address bits 15-10 read zero
// - three scratch registers, one bit-addressable
// - master enable opens four-cycle window
// - write clears strobe; blocks read/address
// - read strobe loads data register
module data_space_decoder
  import dsd_pkg::*;
#(
  parameter int EE_WRITE_CYC = EE_WRITE_CYC_DEF
)
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire cpu_req_t I_REQ,
  input wire logic [15:0] I_POINTER,
  input wire addr_mode_t I_MODE,
  input wire logic [5:0] I_DISP,
  input wire logic I_USE_POINTER,
  input wire logic [7:0] I_FLAG_EVENTS,
  output logic [7:0] O_RDATA,
  output logic O_RVALID,
  output logic O_BIT_TEST,
  output logic O_STALL,
  output logic [15:0] O_POINTER_NEW,
  output logic O_POINTER_WB,
  output logic O_EE_BUSY,
  output logic [7:0] O_FLAGS
);
  logic [15:0] ptr_addr;
  logic [15:0] addr;
  region_t region;
  logic [7:0] regfile [32];
  logic [7:0] sram [SRAM_BYTES];
  logic [7:0] eeprom [EE_BYTES];
  logic [7:0] scratch [3];
  logic [7:0] flags;
  logic [9:0] ee_addr;
  logic [7:0] ee_data;
  logic master_en;
  logic [2:0] master_cnt;
  logic write_busy;
  logic [15:0] write_cnt;
  logic [9:0] wr_addr;
  logic [7:0] wr_data;
  logic sram_pend;
  logic [7:0] rdata;
  logic rvalid;
  logic bit_test;
  logic rd_stall_start;
  logic wr_stall_start;
  logic rd_busy;
  logic wr_busy;
  logic is_io;
  logic [5:0] io_addr;
  logic [7:0] io_old;
  logic [7:0] io_new;
  logic io_we;
  logic bit_op;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic next_bit_test;
  logic [7:0] next_ee_data;
  logic [9:0] next_ee_addr;
  logic next_master_en;
  logic [2:0] next_master_cnt;
  logic start_write;
  logic [7:0] next_flags;

  dsd_pointer_unit u_ptr (
    .i_pointer(I_POINTER),
    .i_mode(I_MODE),
    .i_disp(I_DISP),
    .o_addr(ptr_addr),
    .o_pointer_new(O_POINTER_NEW),
    .o_writeback(O_POINTER_WB)
  );

  // short I/O forms are offset into data space
  always_comb
  begin
    if (I_REQ.io_short)
      addr = {10'h000, I_REQ.addr[5:0]} + IO_TO_DATA;
    else if (I_USE_POINTER)
      addr = ptr_addr;
    else
      addr = I_REQ.addr;
  end

  always_comb
  begin
    if (addr <= REGFILE_HI)
      region = REG_FILE;
    else if (addr <= STDIO_HI)
      region = REG_IO;
    else if (addr <= EXTIO_HI)
      region = REG_EXTIO;
    else if (addr <= SRAM_HI)
      region = REG_SRAM;
    else
      region = REG_NONE;
  end

  assign is_io = (region == REG_IO);
  assign io_addr = 6'(addr - STDIO_LO);
  assign bit_op = (I_REQ.bit_set | I_REQ.bit_clr) && I_REQ.io_short
    && (I_REQ.addr[5:0] <= IO_BIT_MAX);

  always_comb
  begin
    io_old = RESET_BYTE;
    unique case (io_addr)
      IO_SCRATCH0: io_old = scratch[0];
      IO_SCRATCH1: io_old = scratch[1];
      IO_SCRATCH2: io_old = scratch[2];
      IO_FLAGS: io_old = flags;
      IO_EE_CTRL: io_old = {5'h00, master_en, write_busy, 1'b0};
      IO_EE_DATA: io_old = ee_data;
      IO_EE_ADDR_LO: io_old = ee_addr[7:0];
      IO_EE_ADDR_HI: io_old = {6'h00, ee_addr[9:8]};
      default: io_old = UNMAPPED_READ;
    endcase
  end

  // bit ops write only the addressed bit, others as zero
  always_comb
  begin
    io_new = I_REQ.wdata;
    if (bit_op)
      io_new = (I_REQ.bit_set ? 8'h01 : 8'h00) << I_REQ.bit_idx;
  end
  assign io_we = is_io && (I_REQ.wr || bit_op) && !O_STALL;

  always_comb
  begin
    next_flags = flags | I_FLAG_EVENTS;
    if (io_we && io_addr == IO_FLAGS)
    begin
      if (bit_op)
        next_flags = flags & ~(io_new & (8'h01 << I_REQ.bit_idx)) | I_FLAG_EVENTS;
      else
        next_flags = (flags & ~io_new) | I_FLAG_EVENTS;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
      flags <= RESET_BYTE;
    else
      flags <= next_flags;
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_scratch
      logic [5:0] slot;
      logic [7:0] next_val;
      assign slot = (g == 0) ? IO_SCRATCH0 : ((g == 1) ? IO_SCRATCH1 : IO_SCRATCH2);
      always_comb
      begin
        next_val = scratch[g];
        if (io_we && io_addr == slot)
        begin
          if (bit_op)
            next_val[I_REQ.bit_idx] = I_REQ.bit_set;
          else
            next_val = I_REQ.wdata;
        end
      end
      always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
      begin
        if (!I_RST_N)
          scratch[g] <= RESET_BYTE;
        else
          scratch[g] <= next_val;
      end
    end
  endgenerate

  // EEPROM control
  always_comb
  begin
    next_master_en = master_en;
    next_master_cnt = master_cnt;
    next_ee_data = ee_data;
    next_ee_addr = ee_addr;
    start_write = 1'b0;
    rd_stall_start = 1'b0;
    wr_stall_start = 1'b0;
    if (master_en)
    begin
      if (master_cnt == 3'(MASTER_WINDOW_CYC - 1))
        next_master_en = 1'b0;
      next_master_cnt = master_cnt + 3'h1;
    end
    if (io_we)
    begin
      if (io_addr == IO_EE_DATA)
        next_ee_data = I_REQ.wdata;
      if (io_addr == IO_EE_ADDR_LO && !write_busy)
        next_ee_addr[7:0] = I_REQ.wdata;
      if (io_addr == IO_EE_ADDR_HI && !write_busy)
        next_ee_addr[9:8] = I_REQ.wdata[1:0];
      if (io_addr == IO_EE_CTRL)
      begin
        if (io_new[CTL_MASTER_BIT] && !io_new[CTL_WRITE_BIT])
        begin
          next_master_en = 1'b1;
          next_master_cnt = 3'h0;
        end
        if (io_new[CTL_WRITE_BIT] && master_en && !write_busy)
        begin
          start_write = 1'b1;
          wr_stall_start = 1'b1;
          next_master_en = 1'b0;
        end
        if (io_new[CTL_READ_BIT] && !write_busy)
        begin
          next_ee_data = eeprom[ee_addr];
          rd_stall_start = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      master_en <= 1'b0;
      master_cnt <= 3'h0;
      ee_data <= RESET_BYTE;
      ee_addr <= 10'h000;
    end
    else
    begin
      master_en <= next_master_en;
      master_cnt <= next_master_cnt;
      ee_data <= next_ee_data;
      ee_addr <= next_ee_addr;
    end
  end

  // self-timed write engine, deliberately not reset
  always_ff @(posedge I_CLK_SYS)
  begin
    if (start_write)
    begin
      write_busy <= 1'b1;
      write_cnt <= 16'(EE_WRITE_CYC);
      wr_addr <= ee_addr;
      wr_data <= ee_data;
    end
    else if (write_busy)
    begin
      if (write_cnt == 16'h0001)
      begin
        write_busy <= 1'b0;
        eeprom[wr_addr] <= wr_data;
      end
      write_cnt <= write_cnt - 16'h0001;
    end
    else
    begin
      write_busy <= 1'b0;
      write_cnt <= 16'h0000;
    end
  end

  dsd_stall_counter u_rd_stall (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RST_N),
    .i_start(rd_stall_start),
    .i_cycles(3'(READ_STALL_CYC)),
    .o_busy(rd_busy)
  );

  dsd_stall_counter u_wr_stall (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RST_N),
    .i_start(wr_stall_start),
    .i_cycles(3'(WRITE_STALL_CYC)),
    .o_busy(wr_busy)
  );

  assign O_STALL = rd_busy | wr_busy | sram_pend;

  // memories and read path
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!O_STALL && I_REQ.wr && !I_REQ.io_short)
    begin
      if (region == REG_FILE)
        regfile[addr[4:0]] <= I_REQ.wdata;
      if (region == REG_SRAM)
        sram[11'(addr - SRAM_LO)] <= I_REQ.wdata;
    end
  end

  always_comb
  begin
    next_rdata = rdata;
    next_rvalid = 1'b0;
    next_bit_test = bit_test;
    if (!O_STALL && I_REQ.rd)
    begin
      next_rvalid = 1'b1;
      unique case (region)
        REG_FILE: next_rdata = regfile[addr[4:0]];
        REG_IO: next_rdata = io_old;
        REG_EXTIO: next_rdata = UNMAPPED_READ;
        REG_SRAM: next_rdata = sram[11'(addr - SRAM_LO)];
        REG_NONE: next_rdata = UNMAPPED_READ;
      endcase
      if (I_REQ.io_short && I_REQ.addr[5:0] <= IO_BIT_MAX)
        next_bit_test = io_old[I_REQ.bit_idx];
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      rdata <= RESET_BYTE;
      rvalid <= 1'b0;
      bit_test <= 1'b0;
      sram_pend <= 1'b0;
    end
    else
    begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      bit_test <= next_bit_test;
      sram_pend <= !sram_pend && !O_STALL && (I_REQ.rd || I_REQ.wr)
        && region == REG_SRAM;
    end
  end

  assign O_RDATA = rdata;
  assign O_RVALID = rvalid;
  assign O_BIT_TEST = bit_test;
  assign O_EE_BUSY = write_busy;
  assign O_FLAGS = flags;
endmodule : data_space_decoder
`default_nettype wire

// ### tb/dsd_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dsd_chk_sva
  import dsd_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire cpu_req_t I_REQ,
  input wire logic [15:0] I_POINTER,
  input wire addr_mode_t I_MODE,
  input wire logic I_USE_POINTER,
  input wire logic [7:0] O_RDATA,
  input wire logic O_RVALID,
  input wire logic O_STALL,
  input wire logic [15:0] O_POINTER_NEW,
  input wire logic O_POINTER_WB,
  input wire logic O_EE_BUSY
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  wire take = (I_REQ.rd || I_REQ.wr) && !O_STALL;
  wire direct = take && !I_REQ.io_short && !I_USE_POINTER;
  read_answer_a: assert property (I_REQ.rd && !O_STALL |=> O_RVALID)
    else $error("read not answered");
  rvalid_cause_a: assert property (O_RVALID |-> $past(I_REQ.rd && !O_STALL))
    else $error("answer without read");
  unmapped_zero_a: assert property (direct && I_REQ.rd && I_REQ.addr > SRAM_HI
    |=> O_RDATA == UNMAPPED_READ) else $error("unmapped read not zero");
  post_inc_a: assert property (take && I_USE_POINTER && I_MODE == MODE_POSTINC
    |-> O_POINTER_WB && O_POINTER_NEW == I_POINTER + 16'h0001) else $error("bad post-inc");
  pre_dec_a: assert property (take && I_USE_POINTER && I_MODE == MODE_PREDEC
    |-> O_POINTER_WB && O_POINTER_NEW == I_POINTER - 16'h0001) else $error("bad pre-dec");
  stall_bound_a: assert property (O_STALL |-> ##[1:4] !O_STALL)
    else $error("stall too long");
  ee_read_stall_a: assert property (take && I_REQ.wr && I_REQ.io_short
    && I_REQ.addr[5:0] == IO_EE_CTRL && I_REQ.wdata == 8'h01 && !O_EE_BUSY
    |=> O_STALL[*4] ##1 !O_STALL)
    else $error("bad read stall");
  sram_stall_a: assert property (direct && I_REQ.addr inside {[SRAM_LO:SRAM_HI]}
    |=> O_STALL ##1 !O_STALL) else $error("bad sram access time");
endmodule : dsd_chk_sva
bind data_space_decoder dsd_chk_sva u_chk (.I_CLK_SYS, .I_RST_N, .I_REQ, .I_POINTER, .I_MODE,
  .I_USE_POINTER, .O_RDATA, .O_RVALID, .O_STALL, .O_POINTER_NEW, .O_POINTER_WB, .O_EE_BUSY);
`default_nettype wire

// ### tb/dsd_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsd_cpu_model
  import dsd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_stall,
  input wire logic [7:0] i_rdata,
  output cpu_req_t o_req,
  output logic [15:0] o_pointer,
  output addr_mode_t o_mode,
  output logic [5:0] o_disp,
  output logic o_use_pointer
);
  initial
  begin
    o_req = '0;
    o_pointer = 16'h0000;
    o_mode = MODE_PLAIN;
    o_disp = 6'h00;
    o_use_pointer = 1'b0;
  end
  // request held until an edge with stall low
  task automatic access(input cpu_req_t r, output logic [7:0] d);
    @(negedge i_clk);
    o_req = r;
    while (i_stall)
      @(negedge i_clk);
    @(negedge i_clk);
    o_req = '0;
    o_use_pointer = 1'b0;
    d = i_rdata;
  endtask : access
  task automatic wr(input logic io, input logic [15:0] a, input logic [7:0] v);
    logic [7:0] d;
    access({2'b01, io, 5'h00, a, v}, d);
  endtask : wr
  task automatic rd(input logic io, input logic [15:0] a, output logic [7:0] d);
    access({2'b10, io, 5'h00, a, 8'h00}, d);
  endtask : rd
  // k: 0 clear, 1 set, 2 test
  task automatic bit_op(input int k, input logic [2:0] i, input logic [5:0] a);
    logic [7:0] d;
    access({k == 2, k != 2, 1'b1, k == 1, k == 0, i, 10'h000, a, 8'h00}, d);
  endtask : bit_op
  task automatic set_ptr(input addr_mode_t m, input logic [15:0] p, input logic [5:0] s);
    o_use_pointer = 1'b1;
    o_mode = m;
    o_pointer = p;
    o_disp = s;
  endtask : set_ptr
  task automatic ee_write(input logic [9:0] a, input logic [7:0] v);
    wr(1'b1, 16'h0022, {6'h00, a[9:8]});
    wr(1'b1, 16'h0021, a[7:0]);
    wr(1'b1, 16'h0020, v);
    wr(1'b1, 16'h001F, 8'h04);
    wr(1'b1, 16'h001F, 8'h02);
  endtask : ee_write
endmodule : dsd_cpu_model
`default_nettype wire

// ### tb/test_data_space_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module test_data_space_decoder;
  import dsd_pkg::*;
  typedef struct packed {logic [15:0] a; logic io; logic [7:0] v; logic [7:0] e;} row_t;
  row_t rows [9] = '{'{16'h0005, 1'h0, 8'hA5, 8'hA5}, '{16'h003E, 1'h1, 8'h5A, 8'h5A},
    '{16'h004B, 1'h1, 8'h3C, 8'h3C}, '{16'h004A, 1'h1, 8'h96, 8'h96},
    '{16'h0100, 1'h0, 8'h11, 8'h11}, '{16'h08FF, 1'h0, 8'h22, 8'h22},
    '{16'h0900, 1'h0, 8'h33, 8'h00}, '{16'h0080, 1'h0, 8'h44, 8'h00},
    '{16'h0042, 1'h0, 8'hFF, 8'h03}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] events = 8'h00;
  cpu_req_t req;
  logic [15:0] ptr;
  addr_mode_t mode;
  logic [5:0] disp;
  logic use_ptr, bit_test, stall, busy;
  logic [7:0] rdata, flags, d;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  always #5 clk = ~clk;
  data_space_decoder #(.EE_WRITE_CYC(20)) u_dut (.I_CLK_SYS(clk), .I_RST_N(rst_n),
    .I_REQ(req), .I_POINTER(ptr), .I_MODE(mode), .I_DISP(disp), .I_USE_POINTER(use_ptr),
    .I_FLAG_EVENTS(events), .O_RDATA(rdata), .O_RVALID(), .O_BIT_TEST(bit_test),
    .O_STALL(stall), .O_POINTER_NEW(), .O_POINTER_WB(), .O_EE_BUSY(busy), .O_FLAGS(flags));
  dsd_cpu_model u_cpu (.i_clk(clk), .i_stall(stall), .i_rdata(rdata), .o_req(req),
    .o_pointer(ptr), .o_mode(mode), .o_disp(disp), .o_use_pointer(use_ptr));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic wait_stall(input logic [7:0] exp);
    n = 0;
    while (stall === 1'b1 && n < 40)
    begin
      n++;
      @(negedge clk);
    end
    cmp(8'(n), exp);
  endtask : wait_stall
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_fail++;
      finish_test();
    end
  end
  initial
  begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    cmp(flags, 8'h00);
    foreach (rows[i])
    begin
      u_cpu.wr(1'b0, rows[i].a, rows[i].v);
      u_cpu.rd(rows[i].io, rows[i].io ? rows[i].a - IO_TO_DATA : rows[i].a, d);
      cmp(d, rows[i].e);
      $display("row %0d done", i);
    end
    u_cpu.rd(1'b0, 16'h0100, d);
    cmp(d, 8'h11);
    events = 8'h03;
    @(negedge clk);
    events = 8'h00;
    u_cpu.bit_op(1, 3'h5, IO_FLAGS);
    cmp(flags, 8'h03);
    u_cpu.wr(1'b1, {10'h000, IO_FLAGS}, 8'h01);
    cmp(flags, 8'h02);
    u_cpu.wr(1'b1, {10'h000, IO_FLAGS}, 8'h00);
    cmp(flags, 8'h02);
    u_cpu.wr(1'b1, {10'h000, IO_SCRATCH0}, 8'h00);
    u_cpu.bit_op(1, 3'h3, IO_SCRATCH0);
    u_cpu.rd(1'b1, {10'h000, IO_SCRATCH0}, d);
    cmp(d, 8'h08);
    u_cpu.bit_op(2, 3'h3, IO_SCRATCH0);
    cmp({7'h00, bit_test}, 8'h01);
    u_cpu.bit_op(0, 3'h3, IO_SCRATCH0);
    u_cpu.rd(1'b1, {10'h000, IO_SCRATCH0}, d);
    cmp(d, 8'h00);
    $display("bit tests done");
    u_cpu.set_ptr(MODE_DISP, 16'h0100, 6'h3F);
    u_cpu.wr(1'b0, 16'h0000, 8'h77);
    u_cpu.rd(1'b0, 16'h013F, d);
    cmp(d, 8'h77);
    u_cpu.set_ptr(MODE_POSTINC, 16'h0200, 6'h00);
    u_cpu.wr(1'b0, 16'h0000, 8'h55);
    u_cpu.set_ptr(MODE_PREDEC, 16'h0201, 6'h00);
    u_cpu.rd(1'b0, 16'h0000, d);
    cmp(d, 8'h55);
    $display("pointer tests done");
    u_cpu.ee_write(10'h155, 8'hC3);
    wait_stall(8'h02);
    cmp({7'h00, busy}, 8'h01);
    u_cpu.rd(1'b1, {10'h000, IO_EE_CTRL}, d);
    cmp(d, 8'h02);
    u_cpu.wr(1'b1, 16'h0021, 8'h00);
    u_cpu.rd(1'b1, 16'h0021, d);
    cmp(d, 8'h55);
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    cmp({7'h00, busy}, 8'h01);
    n = 0;
    while (busy === 1'b1 && n < 40)
    begin
      n++;
      @(negedge clk);
    end
    cmp({7'h00, busy}, 8'h00);
    u_cpu.rd(1'b1, {10'h000, IO_EE_CTRL}, d);
    cmp(d, 8'h00);
    u_cpu.wr(1'b1, 16'h0022, 8'h01);
    u_cpu.wr(1'b1, 16'h0021, 8'h55);
    u_cpu.wr(1'b1, 16'h001F, 8'h01);
    wait_stall(8'h04);
    u_cpu.rd(1'b1, 16'h0020, d);
    cmp(d, 8'hC3);
    u_cpu.wr(1'b1, 16'h0020, 8'h0F);
    u_cpu.wr(1'b1, 16'h001F, 8'h02);
    u_cpu.wr(1'b1, 16'h001F, 8'h04);
    repeat (6) @(negedge clk);
    u_cpu.wr(1'b1, 16'h001F, 8'h02);
    cmp({7'h00, busy}, 8'h00);
    u_cpu.wr(1'b1, 16'h001F, 8'h01);
    u_cpu.rd(1'b1, 16'h0020, d);
    cmp(d, 8'hC3);
    $display("storage tests done");
    finish_test();
  end
endmodule : test_data_space_decoder
`default_nettype wire
